// ===== rtl/sac_pkg.sv
`default_nettype none

package sac_pkg;

    // Converter geometry
    localparam int unsigned RES_W      = 10;
    localparam int unsigned CH_W       = 4;
    localparam int unsigned CKSEL_W    = 2;
    localparam logic [3:0]  CH_SELF_BIAS = 4'hf;

    // Conversion length in converter clock periods
    localparam int unsigned CONV_PERIODS = 13;
    localparam logic [3:0]  CONV_LAST    = 4'hc;

    // Converter clock dividers of the 250 MHz system clock, per selector code
    // Every code keeps the converter period at 1us or more
    localparam int unsigned CLK_MHZ  = 250;
    localparam int unsigned DIV_W    = 10;
    localparam logic [9:0]  DIV_SEL0 = 10'h0ff;
    localparam logic [9:0]  DIV_SEL1 = 10'h1ff;
    localparam logic [9:0]  DIV_SEL2 = 10'h3ff;
    localparam logic [9:0]  DIV_SEL3 = 10'h17f;

    // Reset values
    localparam logic [9:0]  RESULT_RST = 10'h000;

    typedef enum logic [2:0] {
        SAC_IDLE   = 3'h1,
        SAC_CONV   = 3'h2,
        SAC_FINISH = 3'h4
    } sac_state_type;

    // Control word written by software
    typedef struct packed {
        logic [3:0] channel_select;
        logic       eight_bit_result_mode;
        logic [1:0] clock_select;
    } sac_ctrl_type;

    // Result register image
    typedef struct packed {
        logic [7:0] result_high_reg;
        logic [7:0] result_low_reg;
    } sac_result_type;

endpackage

`default_nettype wire

// ===== rtl/sac_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none

module sac_clkdiv (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_restart,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);

    logic [sac_pkg::DIV_W-1:0] count;
    logic [sac_pkg::DIV_W-1:0] div_max;
    logic                      wrap;

    assign div_max = (i_sel == 2'h0) ? sac_pkg::DIV_SEL0 :
                     (i_sel == 2'h1) ? sac_pkg::DIV_SEL1 :
                     (i_sel == 2'h2) ? sac_pkg::DIV_SEL2 :
                                       sac_pkg::DIV_SEL3;
    assign wrap = (count >= div_max);

    // Restart aligns the first period to the start request
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || i_restart)
        begin
            count  <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            count  <= wrap ? '0 : count + 1'b1;
            o_tick <= wrap;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/sac_core.sv
// Operation
// - Selected input becomes 10-bit approximation code
// - Channel field routes input; 1111b self-bias
// - Start bit begins conversion, self-clears next cycle
// - Full 10-bit result across high/low registers
// - Eight-bit mode puts result in low register
// - Completion loads result, sets done and irq
// - Done bit zero during conversion, one after
// - Conversion takes thirteen converter clock periods
// - Result-high top bits mirror converter clock select
`timescale 1ns/1ps
`default_nettype none

module sac_core (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire sac_pkg::sac_ctrl_type i_ctrl,
    input  wire logic                 i_start_write,
    input  wire logic                 i_irq_ack,
    input  wire logic                 i_comparator,
    output logic                      o_conversion_start_bit,
    output logic                      o_conversion_done_status,
    output logic                      o_converter_irq_flag,
    output logic [3:0]                o_mux_select,
    output logic [9:0]                o_dac_code,
    output logic                      o_sample_hold,
    output sac_pkg::sac_result_type   o_result
);

    ////////////////////////////////////////////////////////////////////
    sac_pkg::sac_state_type state;
    sac_pkg::sac_state_type next_state;
    logic       tick;
    logic [3:0] period;
    logic [3:0] bit_idx;
    logic [9:0] trial;
    logic [9:0] next_trial;
    logic [9:0] code_now;
    logic       converting;
    logic       start_req;
    logic       approx_step;
    logic       last_period;
    logic       finish;
    logic [7:0] low_byte;
    logic [7:0] high_byte;

    assign start_req   = i_start_write && (state == sac_pkg::SAC_IDLE);
    assign converting  = (state == sac_pkg::SAC_CONV);
    assign last_period = (period == sac_pkg::CONV_LAST);
    // Periods 0 and 1 sample; 2..11 resolve one bit each, MSB first
    assign approx_step = converting && tick && (period >= 4'h2)
                         && (period <= 4'hb);
    assign bit_idx     = 4'hb - period;
    assign finish      = (state == sac_pkg::SAC_FINISH);

    always_comb
    begin
        next_trial = trial;
        if (approx_step)
        begin
            if (!i_comparator)
                next_trial[bit_idx] = 1'b0;
            if (bit_idx != 4'h0)
                next_trial[bit_idx - 4'h1] = 1'b1;
        end
    end
    assign code_now = next_trial;

    // Clock reset at start keeps the 13 periods whole
    sac_clkdiv u_clkdiv (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_restart (start_req),
        .i_sel     (i_ctrl.clock_select),
        .o_tick    (tick)
    );

    always_comb
    begin
        next_state = state;
        unique case (state)
            sac_pkg::SAC_IDLE:
                if (start_req)
                    next_state = sac_pkg::SAC_CONV;
            sac_pkg::SAC_CONV:
                if (tick && last_period)
                    next_state = sac_pkg::SAC_FINISH;
            sac_pkg::SAC_FINISH:
                next_state = sac_pkg::SAC_IDLE;
            default:
                next_state = sac_pkg::SAC_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state  <= sac_pkg::SAC_IDLE;
            period <= 4'h0;
            trial  <= 10'h000;
        end
        else
        begin
            state  <= next_state;
            period <= start_req ? 4'h0 : (tick ? period + 4'h1 : period);
            trial  <= start_req ? 10'h200 : next_trial;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_conversion_start_bit <= 1'b0;
        else
            o_conversion_start_bit <= start_req;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_mux_select  <= 4'h0;
            o_dac_code    <= 10'h000;
            o_sample_hold <= 1'b0;
        end
        else
        begin
            o_mux_select  <= i_ctrl.channel_select;
            o_dac_code    <= code_now;
            o_sample_hold <= start_req || (converting && period < 4'h2);
        end
    end

    // Eight-bit mode drops two LSBs into low byte
    assign low_byte  = i_ctrl.eight_bit_result_mode ? trial[9:2]
                                                    : trial[7:0];
    // Top bits carry clock select, not result
    assign high_byte = {i_ctrl.clock_select, 3'h0,
                        i_ctrl.eight_bit_result_mode,
                        i_ctrl.eight_bit_result_mode ? 2'h0 : trial[9:8]};

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_result <= '0;
        else if (finish)
        begin
            o_result.result_low_reg  <= low_byte;
            o_result.result_high_reg <= high_byte;
        end
        else
            o_result.result_high_reg[7:5] <= {i_ctrl.clock_select, 1'b0};
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_conversion_done_status <= 1'b0;
        else if (start_req)
            o_conversion_done_status <= 1'b0;
        else if (finish)
            o_conversion_done_status <= 1'b1;
    end

    // Sticky irq, set wins over ack
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_converter_irq_flag <= 1'b0;
        else if (finish)
            o_converter_irq_flag <= 1'b1;
        else if (i_irq_ack)
            o_converter_irq_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    property p_start_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_conversion_start_bit |=> !o_conversion_start_bit;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start bit not self-cleared");

    property p_done_low;
        @(posedge i_clk) disable iff (!i_rst_n)
        converting |-> !o_conversion_done_status;
    endproperty
    a_done_low: assert property (p_done_low)
        else $error("done set during conversion");

    property p_finish_flags;
        @(posedge i_clk) disable iff (!i_rst_n)
        finish |=> o_conversion_done_status && o_converter_irq_flag;
    endproperty
    a_finish_flags: assert property (p_finish_flags)
        else $error("flags missing after completion");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        !finish |=> o_result.result_low_reg
                    == $past(o_result.result_low_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed without completion");

    property p_irq_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_converter_irq_flag && !i_irq_ack |=> o_converter_irq_flag;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("irq flag dropped without ack");

    property p_periods;
        @(posedge i_clk) disable iff (!i_rst_n)
        finish |-> period == 4'hd;
    endproperty
    a_periods: assert property (p_periods)
        else $error("conversion length wrong");

    property p_eight;
        @(posedge i_clk) disable iff (!i_rst_n)
        finish && i_ctrl.eight_bit_result_mode
        |=> o_result.result_low_reg == $past(trial[9:2]);
    endproperty
    a_eight: assert property (p_eight)
        else $error("eight-bit result misplaced");

    property p_full;
        @(posedge i_clk) disable iff (!i_rst_n)
        finish && !i_ctrl.eight_bit_result_mode
        |=> {o_result.result_high_reg[1:0], o_result.result_low_reg}
            == $past(trial);
    endproperty
    a_full: assert property (p_full)
        else $error("ten-bit result misplaced");

    property p_cksel;
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_result.result_high_reg[7:6] == $past(i_ctrl.clock_select);
    endproperty
    a_cksel: assert property (p_cksel)
        else $error("clock select bits not mirrored");

    c_conv: cover property (@(posedge i_clk) finish);
    c_eight: cover property (@(posedge i_clk)
        finish && i_ctrl.eight_bit_result_mode);
    c_bias: cover property (@(posedge i_clk)
        start_req && i_ctrl.channel_select == sac_pkg::CH_SELF_BIAS);

endmodule

`default_nettype wire

// ===== tb/sar_adc_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_control_bench;
    logic                    i_clk = 1'b0;
    logic                    i_rst_n = 1'b0;
    sac_pkg::sac_ctrl_type   i_ctrl = '0;
    logic                    i_start_write = 1'b0;
    logic                    i_irq_ack = 1'b0;
    logic                    i_comparator = 1'b0;
    logic                    start_bit;
    logic                    done;
    logic                    irq;
    logic [3:0]              mux;
    logic [9:0]              dac;
    logic                    hold;
    sac_pkg::sac_result_type res;
    logic [9:0]              target = '0;
    logic [9:0]              divs [4] = '{sac_pkg::DIV_SEL0,
        sac_pkg::DIV_SEL1, sac_pkg::DIV_SEL2, sac_pkg::DIV_SEL3};
    logic [15:0]             q_res [$];
    int                      q_len [$];
    int                      err_count = 0;
    int                      comparisons = 0;
    int                      seed = 32'hb75f1c95;
    int                      run = 0;
    logic                    done_q = 1'b0;

    always #2 i_clk = ~i_clk;

    sac_core DUT (
        .i_clk                    (i_clk),
        .i_rst_n                  (i_rst_n),
        .i_ctrl                   (i_ctrl),
        .i_start_write            (i_start_write),
        .i_irq_ack                (i_irq_ack),
        .i_comparator             (i_comparator),
        .o_conversion_start_bit   (start_bit),
        .o_conversion_done_status (done),
        .o_converter_irq_flag     (irq),
        .o_mux_select             (mux),
        .o_dac_code               (dac),
        .o_sample_hold            (hold),
        .o_result                 (res)
    );

    ////////////////////////////////////////////////////////////////////////
    // Analog side: input at or above trial code reads one
    always @(posedge i_clk) #1 i_comparator = (target >= dac);

    task automatic check_res(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitor: completion against oldest note
    always @(posedge i_clk)
    begin
        #2;
        run = start_bit ? 1 : run + 1;
        if (done === 1'b1 && done_q === 1'b0)
        begin
            if (q_res.size() == 0)
                check_flag(1'b0, 1'b1);
            else
            begin
                check_res(res, q_res.pop_front());
                check_flag(irq, 1'b1);
                check_flag(1'(run >= q_len[0] - 2 && run <= q_len[0] + 6),
                    1'b1);
                void'(q_len.pop_front());
            end
        end
        done_q = done;
    end

    ////////////////////////////////////////////////////////////////////////
    // One conversion, with a refused start in mid-run
    task automatic convert(input logic [1:0] sel, input logic mode,
                           input logic [3:0] ch);
        logic [9:0] prev;
        int         n;
        prev = res[9:0];
        i_ctrl = '{channel_select: ch, eight_bit_result_mode: mode,
                   clock_select: sel};
        target = 10'($random(seed));
        q_res.push_back({sel, 3'h0, mode, mode ? 2'h0 : target[9:8],
                         mode ? target[9:2] : target[7:0]});
        q_len.push_back(13 * (int'(divs[sel]) + 1));
        step(1);
        i_start_write = 1'b1;
        step(1);
        i_start_write = 1'b0;
        check_flag(start_bit, 1'b1);
        check_flag(done, 1'b0);
        check_res(16'(mux), 16'(ch));
        check_flag(hold, 1'b1);
        step(1);
        check_flag(start_bit, 1'b0);
        check_res(16'(dac), 16'h0200);
        // Busy: this start must be ignored
        i_start_write = 1'b1;
        step(1);
        i_start_write = 1'b0;
        check_flag(start_bit, 1'b0);
        step(100);
        check_flag(done, 1'b0);
        check_res(16'(res[9:0]), 16'(prev));
        n = 0;
        while (done !== 1'b1 && n < 14000)
        begin
            step(1);
            n++;
        end
        if (n >= 14000)
        begin
            err_count++;
            complete_run();
        end
        else
        begin
            step(3);
            check_flag(irq, 1'b1);
            check_res(16'(dac), 16'(target));
            i_irq_ack = 1'b1;
            step(1);
            i_irq_ack = 1'b0;
            check_flag(irq, 1'b0);
            check_flag(done, 1'b1);
            check_flag(hold, 1'b0);
        end
    endtask

    initial
    begin
        step(10);
        i_rst_n = 1'b1;
        check_res(res, 16'h0000);
        check_flag(done, 1'b0);
        check_flag(irq, 1'b0);
        // All selectors give 1us or more
        convert(2'h3, 1'b0, 4'h0);
        convert(2'h0, 1'b1, sac_pkg::CH_SELF_BIAS);
        convert(2'h1, 1'b0, 4'h5);
        convert(2'h2, 1'b1, 4'($random(seed)));
        convert(2'h3, 1'b1, 4'($random(seed)));
        complete_run();
    end
endmodule

`default_nettype wire
